/* lcc_pkg.sv */
package lcc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [9:0] IDX_ACT_PATTERN = 10'h12b;  // rx_act_pattern register
    localparam logic [9:0] IDX_DEACT_PATTERN = 10'h12c;  // rx_deactivation_pattern
    localparam logic [9:0] IDX_LEN_CTRL = 10'h12d;  // loop_code_length_ctrl
    // reset values: pattern 1010101 in bits 7-1, enable 0 in bit 0
    localparam logic [7:0] RST_PATTERN = 8'haa;
    localparam logic [7:0] RST_LEN_CTRL = 8'h00;
    // field positions
    localparam int PAT_MSB = 7;
    localparam int PAT_LSB = 1;
    localparam int EN_BIT = 0;
    localparam int ACT_LEN_MSB = 7;
    localparam int ACT_LEN_LSB = 6;
    localparam int DEACT_LEN_MSB = 5;
    localparam int DEACT_LEN_LSB = 4;
    localparam int TX_LEN_MSB = 3;
    localparam int TX_LEN_LSB = 2;
    localparam int FRAMED_BIT = 1;
    localparam int AUTO_BIT = 0;
    // shortest code sequence, selected by length code 00
    localparam logic [2:0] MIN_CODE_LEN = 3'h4;
    localparam int PAT_BITS = 7;
    // bits of continuous repetition before a code is declared
    localparam logic [5:0] DETECT_BITS = 6'h30;
    // bus encodings
    localparam logic HTRANS_ACTIVE_BIT = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;

    // configuration handed to the detector and generator
    typedef struct packed {
        logic [6:0] act_pattern;
        logic act_en;
        logic [6:0] deact_pattern;
        logic deact_en;
        logic [1:0] act_len;
        logic [1:0] deact_len;
        logic [1:0] tx_len;
        logic framed;
        logic auto_en;
    } lcc_cfg_t;

    // remote loopback state
    typedef enum logic {LCC_LOOP_OFF, LCC_LOOP_ON} lcc_loop_t;
endpackage

/* lcc_loopback_code_config.sv */
`timescale 1ns/1ps
// Overview of operation
// - seven-bit deactivation pattern, reset 1010101, read/write
// - pattern msb is first bit received
// - bit 0 enables deactivation search, reset off
// - deactivation length taken from control register
// - activation length field 7-6: four to seven
// - deactivation length field 5-4: four to seven
// - transmit length field 3-2, 00 is four
// - auto loopback left on deactivation detect
// - activation pattern, reset 1010101, enters loopback
module lcc_loopback_code_config (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_line_clk,
    input wire logic rx_line_data,
    output lcc_pkg::lcc_cfg_t cfg,
    output logic [2:0] tx_code_len,
    output logic act_detected,
    output logic deact_detected,
    output logic remote_loop_active
);
    import lcc_pkg::*;

    // the block keeps the loopback code settings and watches the receive
    // line for both codes; the code generator only reads cfg and tx_code_len
    // everything runs on hclk; the two line pins are treated as asynchronous
    // and filtered before any decision is taken from them

    // number of bits selected by a two-bit length code
    // codes 00..11 map onto four..seven bits; one function serves all three
    // length fields so the receive and transmit sides cannot drift apart
    function automatic logic [2:0] len_bits(input logic [1:0] sel);
        len_bits = MIN_CODE_LEN + {1'b0, sel};
    endfunction

    // newest n history bits against the first n pattern bits, msb first
    // slots past n are ignored, so a short code only looks at its newest bits
    // the loop covers all seven slots to keep the compare a fixed structure
    function automatic logic match_fn(input logic [6:0] hist, input logic [6:0] pat,
                                      input logic [2:0] n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < PAT_BITS; i++) begin
            if (i < int'(n) && hist[i] != pat[PAT_BITS - int'(n) + i]) begin
                ok = 1'b0;
            end
        end
        match_fn = ok;
    endfunction

    // bit received n bits before the one now arriving
    // n is never below four, so the index always stays inside the history
    function automatic logic period_bit(input logic [6:0] hist, input logic [2:0] n);
        period_bit = hist[n - 3'h1];
    endfunction

    // saturating run of bits that kept the code period
    // saturation stops a long code from wrapping into a false restart
    function automatic logic [5:0] run_fn(input logic [5:0] run, input logic keep);
        if (!keep) begin
            run_fn = 6'h00;
        end else if (run == DETECT_BITS) begin
            run_fn = run;
        end else begin
            run_fn = run + 6'h01;
        end
    endfunction

    // register storage
    // only the low byte of a write is kept; the upper bits read back zero
    logic [7:0] act_ff;  // activation pattern and enable
    logic [7:0] deact_ff;  // deactivation pattern and enable
    logic [7:0] len_ff;  // length and mode control
    logic [7:0] nxt_act;
    logic [7:0] nxt_deact;
    logic [7:0] nxt_len;

    // bus pipeline
    // hsize is not decoded: every register is one whole word
    logic wr_pend_ff;  // write data phase pending
    logic [9:0] wr_idx_ff;  // index captured in address phase
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;

    // line sampling
    // the first stage may go metastable; only stages two and three are compared
    logic clk_s1_ff;  // line clock, first stage
    logic clk_s2_ff;  // line clock, second stage
    logic clk_s3_ff;  // line clock, third stage
    logic clk_lvl_ff;  // filtered line clock level
    logic dat_s1_ff;  // line data, first stage
    logic dat_s2_ff;  // line data, second stage
    logic dat_s3_ff;  // line data, third stage
    logic dat_lvl_ff;  // filtered line data level
    logic [6:0] hist_ff;  // hist_ff[0] is the newest received bit

    // detectors and loop state
    // each detector keeps its own run so both codes are hunted at once
    logic [5:0] act_run_ff;  // periodic run length, activation
    logic [5:0] deact_run_ff;  // periodic run length, deactivation
    logic act_seen_ff;  // activation pattern met inside the run
    logic deact_seen_ff;  // deactivation pattern met inside the run
    logic act_det_ff;  // activation code present
    logic deact_det_ff;  // deactivation code present
    lcc_loop_t loop_ff;  // remote loopback state
    logic loop_on_ff;  // registered copy of the loop state for the port
    lcc_cfg_t cfg_ff;
    logic [2:0] tx_len_ff;

    // address phase decode
    // idle or busy transfers, and cycles where the bus is stalled, are ignored
    wire addr_ok = hsel & hready & (htrans[1] == HTRANS_ACTIVE_BIT);
    wire rd_req = addr_ok & ~hwrite;
    wire wr_req = addr_ok & hwrite;
    wire [9:0] rd_idx = haddr[11:2];
    wire idx_hi_zero = (haddr[31:12] == 20'h00000);
    wire [7:0] wbyte = hwdata[7:0];

    // register writes land in the data phase
    // hwdata arrives one cycle after its address, hence the pending flag
    assign nxt_act = (wr_pend_ff && wr_idx_ff == IDX_ACT_PATTERN) ? wbyte : act_ff;
    assign nxt_deact = (wr_pend_ff && wr_idx_ff == IDX_DEACT_PATTERN) ? wbyte : deact_ff;
    assign nxt_len = (wr_pend_ff && wr_idx_ff == IDX_LEN_CTRL) ? wbyte : len_ff;

    // read mux sees this cycle's write so back-to-back write then read is coherent
    wire [7:0] rd_byte = !idx_hi_zero ? 8'h00 :
                         (rd_idx == IDX_ACT_PATTERN) ? nxt_act :
                         (rd_idx == IDX_DEACT_PATTERN) ? nxt_deact :
                         (rd_idx == IDX_LEN_CTRL) ? nxt_len : 8'h00;

    // register file, asynchronously reset to its defaults
    // software sees the default patterns right after reset is released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_ff <= RST_PATTERN;
            deact_ff <= RST_PATTERN;
            len_ff <= RST_LEN_CTRL;
        end else begin
            act_ff <= nxt_act;
            deact_ff <= nxt_deact;
            len_ff <= nxt_len;
        end
    end

    // bus slave: zero wait states, always okay
    // the slave never stalls, so hreadyout stays high in and out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 10'h000;
            hrdata_ff <= 32'h00000000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= HRESP_OKAY;
        end else begin
            // nonzero high address bits cancel the pending write
            wr_pend_ff <= wr_req & idx_hi_zero;
            wr_idx_ff <= rd_idx;
            hreadyout_ff <= 1'b1;
            hresp_ff <= HRESP_OKAY;
            if (rd_req) begin
                hrdata_ff <= {24'h000000, rd_byte};
            end
        end
    end

    // line inputs: three stages, a change counts once stages two and three agree
    // a glitch shorter than two clocks never reaches the detectors
    // limitation: each half of the line clock must last at least three hclk
    wire nxt_clk_lvl = (clk_s2_ff == clk_s3_ff) ? clk_s3_ff : clk_lvl_ff;
    wire nxt_dat_lvl = (dat_s2_ff == dat_s3_ff) ? dat_s3_ff : dat_lvl_ff;
    wire bit_stb = nxt_clk_lvl & ~clk_lvl_ff;  // rising edge of filtered line clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {clk_s1_ff, clk_s2_ff, clk_s3_ff, clk_lvl_ff} <= 4'h0;
            {dat_s1_ff, dat_s2_ff, dat_s3_ff, dat_lvl_ff} <= 4'h0;
        end else begin
            {clk_s1_ff, clk_s2_ff, clk_s3_ff} <= {rx_line_clk, clk_s1_ff, clk_s2_ff};
            {dat_s1_ff, dat_s2_ff, dat_s3_ff} <= {rx_line_data, dat_s1_ff, dat_s2_ff};
            clk_lvl_ff <= nxt_clk_lvl;
            dat_lvl_ff <= nxt_dat_lvl;
        end
    end

    // decoded fields
    // the framed bit is stored and handed on but plays no part in detection
    wire [2:0] act_n = len_bits(len_ff[ACT_LEN_MSB:ACT_LEN_LSB]);
    wire [2:0] deact_n = len_bits(len_ff[DEACT_LEN_MSB:DEACT_LEN_LSB]);
    wire act_en = act_ff[EN_BIT];
    wire deact_en = deact_ff[EN_BIT];
    wire auto_en = len_ff[AUTO_BIT];
    wire [6:0] nxt_hist = {hist_ff[5:0], nxt_dat_lvl};  // first bit ends up oldest
    // a bit keeps the period when it equals the one received n bits earlier
    wire act_keep = nxt_dat_lvl == period_bit(hist_ff, act_n);
    wire deact_keep = nxt_dat_lvl == period_bit(hist_ff, deact_n);
    // pattern msb compared against the oldest bit of the window
    wire act_hit = match_fn(nxt_hist, act_ff[PAT_MSB:PAT_LSB], act_n);
    wire deact_hit = match_fn(nxt_hist, deact_ff[PAT_MSB:PAT_LSB], deact_n);
    wire [5:0] nxt_act_run = run_fn(act_run_ff, act_keep);
    wire [5:0] nxt_deact_run = run_fn(deact_run_ff, deact_keep);
    // the pattern must appear at least once inside an unbroken periodic run
    wire nxt_act_seen = act_keep & (act_seen_ff | act_hit);
    wire nxt_deact_seen = deact_keep & (deact_seen_ff | deact_hit);
    wire nxt_act_det = (nxt_act_run == DETECT_BITS) & nxt_act_seen;
    wire nxt_deact_det = (nxt_deact_run == DETECT_BITS) & nxt_deact_seen;

    // detectors advance once per received bit; a disabled one is held cleared
    // trade-off: clearing on disable costs a full fresh run after re-enable,
    // but a stale detection can never survive a pattern change written with the enable bit clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hist_ff <= 7'h00;
            {act_run_ff, act_seen_ff, act_det_ff} <= 8'h00;
            {deact_run_ff, deact_seen_ff, deact_det_ff} <= 8'h00;
        end else begin
            if (bit_stb) begin
                hist_ff <= nxt_hist;
            end
            if (!act_en) begin
                {act_run_ff, act_seen_ff, act_det_ff} <= 8'h00;
            end else if (bit_stb) begin
                {act_run_ff, act_seen_ff, act_det_ff} <= {nxt_act_run, nxt_act_seen, nxt_act_det};
            end
            if (!deact_en) begin
                {deact_run_ff, deact_seen_ff, deact_det_ff} <= 8'h00;
            end else if (bit_stb) begin
                {deact_run_ff, deact_seen_ff, deact_det_ff} <=
                    {nxt_deact_run, nxt_deact_seen, nxt_deact_det};
            end
        end
    end

    // remote loopback follows detections only while auto mode is on;
    // leaving auto mode also drops the loop so software can always recover;
    // deactivation wins if both codes are somehow seen together
    lcc_loop_t nxt_loop;
    always_comb begin
        nxt_loop = loop_ff;
        unique case (loop_ff)
            LCC_LOOP_OFF: begin
                if (auto_en && act_det_ff && !deact_det_ff) begin
                    nxt_loop = LCC_LOOP_ON;
                end
            end
            LCC_LOOP_ON: begin
                if (!auto_en || deact_det_ff) begin
                    nxt_loop = LCC_LOOP_OFF;
                end
            end
        endcase
    end

    // output registers so every port comes straight from a flop
    // cfg and tx_code_len use the next register values, so they show a
    // write one cycle after its data phase, together with the register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_ff <= LCC_LOOP_OFF;
            loop_on_ff <= 1'b0;
            cfg_ff <= '0;
            tx_len_ff <= MIN_CODE_LEN;
        end else begin
            loop_ff <= nxt_loop;
            loop_on_ff <= (nxt_loop == LCC_LOOP_ON);
            cfg_ff <= {nxt_act, nxt_deact, nxt_len[ACT_LEN_MSB:ACT_LEN_LSB],
                       nxt_len[DEACT_LEN_MSB:DEACT_LEN_LSB], nxt_len[TX_LEN_MSB:TX_LEN_LSB],
                       nxt_len[FRAMED_BIT], nxt_len[AUTO_BIT]};
            tx_len_ff <= len_bits(nxt_len[TX_LEN_MSB:TX_LEN_LSB]);
        end
    end

    // ports driven straight from their registers
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign cfg = cfg_ff;
    assign tx_code_len = tx_len_ff;
    assign act_detected = act_det_ff;
    assign deact_detected = deact_det_ff;
    assign remote_loop_active = loop_on_ff;
endmodule

/* lcc_assertions.sv */
`timescale 1ns/1ps
// watches bus answers, configuration outputs and loopback state
module lcc_chk
    import lcc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire lcc_pkg::lcc_cfg_t cfg,
    input wire logic [2:0] tx_code_len,
    input wire logic act_detected,
    input wire logic deact_detected,
    input wire logic remote_loop_active
);
    logic wr_ff; // write data phase under way
    logic [9:0] idx_ff; // word index of that write
    logic [7:0] wd_ff; // byte it stored; only the low byte is kept
    // follow write data phases so the config outputs can be tied to them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            idx_ff <= '0;
            wd_ff <= '0;
        end else begin
            wr_ff <= hsel && hready && htrans[1] && hwrite && haddr[31:12] == 20'h0;
            idx_ff <= haddr[11:2];
            if (wr_ff) wd_ff <= hwdata[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready or not okay");
    chk_deact_write: assert property (wr_ff && idx_ff == IDX_DEACT_PATTERN
        |-> ##[1:2] {cfg.deact_pattern, cfg.deact_en} == wd_ff) else $error("deact reg lost");
    chk_act_write: assert property (wr_ff && idx_ff == IDX_ACT_PATTERN
        |-> ##[1:2] {cfg.act_pattern, cfg.act_en} == wd_ff) else $error("act reg lost");
    chk_ctrl_write: assert property (wr_ff && idx_ff == IDX_LEN_CTRL |-> ##[1:2]
        {cfg.act_len, cfg.deact_len, cfg.tx_len, cfg.framed, cfg.auto_en} == wd_ff)
        else $error("length control lost");
    // three stable cycles of cfg.tx_len keep a one-cycle skew from firing it
    chk_tx_len_map: assert property ($stable(cfg.tx_len) [*3]
        |-> $past(tx_code_len) == MIN_CODE_LEN + 3'(cfg.tx_len)) else $error("tx length wrong");
    chk_deact_gate: assert property (!cfg.deact_en |-> ##1 !deact_detected)
        else $error("deact detected while disabled");
    chk_loop_enter: assert property ($rose(remote_loop_active)
        |-> $past(act_detected) && !$past(deact_detected)) else $error("loop entered early");
    chk_loop_leave: assert property (deact_detected |=> !remote_loop_active)
        else $error("loop kept after deact code");
endmodule
bind lcc_loopback_code_config lcc_chk chk_i (.*);

/* lcc_line_partner.sv */
`timescale 1ns/1ps
// far-end line equipment: repeats a loopback code msb first
module lcc_line_partner (
    input wire logic hclk,
    input wire logic run,
    input wire logic [6:0] code,
    input wire logic [2:0] len,
    output logic line_clk,
    output logic line_data
);
    logic [2:0] ph_ff = 3'h0; // hclk phase within one line bit
    logic [2:0] pos_ff = 3'h6; // code bit sent next, 6 is the msb
    initial begin
        line_clk = 1'b0;
        line_data = 1'b0;
    end
    // eight hclk per bit, four low and four high, so the filter sees both halves
    always @(posedge hclk) begin
        if (!run) begin
            line_clk <= 1'b0; // clock stands still between bursts
            line_data <= ~line_data; // idle line shows no stale bit
            ph_ff <= 3'h0;
            pos_ff <= 3'h6;
        end else begin
            ph_ff <= ph_ff + 3'h1;
            line_clk <= ph_ff[2];
            if (ph_ff == 3'h0) begin
                line_data <= code[pos_ff];
                pos_ff <= (pos_ff <= 3'h7 - len) ? 3'h6 : pos_ff - 3'h1;
            end
        end
    end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import lcc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0, rd_ff = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rnd = 32'h4f; // seed 79
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2, tx_code_len, len = 3'h7;
    logic [6:0] code = '0;
    logic hready, hreadyout, hresp, rx_line_clk, rx_line_data;
    logic act_detected, deact_detected, remote_loop_active;
    lcc_cfg_t cfg;
    logic [31:0] expq[$]; // expected read words, oldest first
    int fails = 0, checks = 0, cyc = 0;
    assign hready = hreadyout; // single slave drives the bus ready
    always #10 hclk = ~hclk;
    lcc_loopback_code_config DUT (.*);
    lcc_line_partner line (.hclk(hclk), .run(run), .code(code), .len(len),
        .line_clk(rx_line_clk), .line_data(rx_line_data));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // one single transfer; waits on ready instead of assuming zero wait
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic wait_loop(input logic v);
        for (int i = 0; i < 1500 && remote_loop_active !== v; i++) @(posedge hclk);
        @(negedge hclk);
    endtask
    task automatic summarize();
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // read data phase: compare hrdata with the oldest note
    always @(posedge hclk) begin
        if (rd_ff && hready === 1'b1) chk("hrdata", expq.pop_front(), hrdata);
        rd_ff <= hsel && htrans[1] && !hwrite && hready;
    end
    // hang guard, well above the two detection runs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'h4ac, {24'h0, RST_PATTERN});
        rd(32'h4b0, {24'h0, RST_PATTERN});
        rd(32'h4b4, {24'h0, RST_LEN_CTRL});
        chk("cfg", {RST_PATTERN, RST_PATTERN, RST_LEN_CTRL}, {8'h0, cfg});
        xfer(1'b1, 32'h4b8, 32'hff); // unmapped word must stay empty
        rd(32'h4b8, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            xfer(1'b1, 32'h4b0, rnd);
            rd(32'h4b0, {24'h0, rnd[7:0]});
        end
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 32'h4b4, {24'h0, 2'(c), 2'(c), 2'(c), 2'b00});
            rd(32'h4b4, {24'h0, 2'(c), 2'(c), 2'(c), 2'b00});
            @(negedge hclk);
            chk("tx_code_len", 32'(MIN_CODE_LEN) + 32'(c), {29'h0, tx_code_len});
            @(posedge hclk);
        end
        // codes chosen so a reversed bit order would not match
        xfer(1'b1, 32'h4b0, 32'hc9);
        xfer(1'b1, 32'h4ac, 32'hd1);
        xfer(1'b1, 32'h4b4, 32'he1);
        code <= 7'h68;
        run <= 1'b1;
        wait_loop(1'b1);
        chk("loop_on", 32'h1, {31'h0, remote_loop_active});
        chk("act_detected", 32'h1, {31'h0, act_detected});
        chk("deact_idle", 32'h0, {31'h0, deact_detected});
        @(posedge hclk);
        code <= 7'h64;
        len <= 3'h6;
        wait_loop(1'b0);
        chk("loop_off", 32'h0, {31'h0, remote_loop_active});
        chk("deact_detected", 32'h1, {31'h0, deact_detected});
        @(posedge hclk);
        xfer(1'b1, 32'h4b0, 32'hc8);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk("deact_off", 32'h0, {31'h0, deact_detected});
        summarize();
    end
endmodule
